// ==== inc/csa_ctrl_pkg.sv ====
// Shared constants and types for the shunt amplifier control block
package csa_ctrl_pkg;
  localparam int unsigned n_amps = 3;
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] trim_addr = 8'h04;
  localparam logic [7:0] status_addr = 8'h08;
  localparam logic [7:0] route_addr = 8'h0c;
  localparam int unsigned ctl_vref_full_bit = 0;
  localparam int unsigned ctl_xdrop_bit = 1;
  localparam int unsigned ctl_lsref_bit = 2;
  localparam int unsigned ctl_runtrim_bit = 3;
  localparam int unsigned ctl_gain_lsb = 4;
  localparam int unsigned ctl_swif_bit = 6;
  localparam logic [31:0] ctrl_reset = 32'h0000_0040;
  localparam logic [1:0] gain_max = 2'h3;
  localparam int unsigned clk_hz = 40_000_000;
  localparam int unsigned trim_time_us = 50;
  localparam int unsigned trim_cycles = trim_time_us * (clk_hz / 1_000_000);
  localparam int unsigned step_cycles = 16;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [2:0] {
    st_wait_ref = 3'b001,
    st_trim = 3'b010,
    st_run = 3'b100
  } trim_state_e;

  typedef struct packed {
    logic cal_short;
    logic load_off;
    logic pos_to_phase;
    logic in_short;
    logic out_valid;
    logic bidir;
  } amp_route_s;
endpackage

// ==== logic/amp_lane.sv ====
// One amplifier lane: input routing and transistor-drop sequencing
module amp_lane
  import csa_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic man_cal,
  input wire logic auto_trim,
  input wire logic xdrop,
  input wire logic vref_full,
  input wire logic drive_done,
  input wire logic ls_off_cmd,
  output csa_ctrl_pkg::amp_route_s route
);
  import csa_ctrl_pkg::*;
  amp_route_s route_r, route_nxt;
  logic armed_r, armed_nxt;

  always_comb begin
    armed_nxt = armed_r;
    if (!xdrop) begin
      armed_nxt = 1'b0;
    end else if (ls_off_cmd) begin
      armed_nxt = 1'b0;
    end else if (drive_done) begin
      armed_nxt = 1'b1; // RQ14
    end
    route_nxt.bidir = !vref_full; // RQ1
    route_nxt.cal_short = man_cal; // RQ2 RQ3 RQ18
    route_nxt.load_off = man_cal; // RQ2
    route_nxt.pos_to_phase = xdrop; // RQ12
    route_nxt.in_short = man_cal || (xdrop && ls_off_cmd); // RQ15
    route_nxt.out_valid = !man_cal && !auto_trim && (!xdrop || armed_nxt); // RQ14 RQ9
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_r <= 1'b0;
      route_r <= '0;
    end else begin
      armed_r <= armed_nxt;
      route_r <= route_nxt;
    end
  end

  assign route = route_r;
endmodule

// ==== logic/shunt_amp_cal_mode_ctrl.sv ====
// Shunt amplifier mode, calibration and trim sequencing with AXI4-Lite registers
// Operation
// RQ1: Reference divider removed means unidirectional output, shunt difference times gain.
// RQ2: Manual calibration shorts amplifier inputs and disconnects its load.
// RQ3: Each trim bit puts only its own amplifier into calibration.
// RQ4: Manual calibration accepted anytime, never stalls gate drive.
// RQ5: Controller should calibrate during switching off time, recommended only.
// RQ6: Manual calibration exists only on register-interface variants.
// RQ7: Automatic trim starts at power-up once reference crosses minimum level.
// RQ8: Controller waits 50 us after reference valid before trusting outputs.
// RQ9: Trim minimises offset, then amplifiers enter normal operation.
// RQ10: With runtime trim enabled, a trim bit reruns automatic trim.
// RQ11: All amplifiers forced to maximum gain while any trim runs.
// RQ12: Transistor-drop select routes positive input to phase node via clamp.
// RQ13: Transistor-drop select forces low-side monitor reference to shunt negative.
// RQ14: Drop mode enables amplifier output only after gate-drive window.
// RQ15: Drop mode low-side turn-off command shorts that amplifier's shunt inputs.
// RQ16: Gain selectable among 5, 10, 20 or 40 V/V.
// RQ17: Monitor reference select picks shunt positive or negative; high side fixed.
// RQ18: Clearing a trim bit ends manual calibration and restores normal operation.
// RQ19: Completed automatic trim restores the programmed gain.
module shunt_amp_cal_mode_ctrl
  import csa_ctrl_pkg::*;
#(
  parameter int unsigned trim_len = trim_cycles
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vref_ok,
  input wire logic [2:0] gate_drive_window_done,
  input wire logic [2:0] lowside_off_cmd,
  output logic [1:0] amp_gain,
  output logic [2:0] amp_trim_active,
  output logic lowside_monitor_ref_neg,
  output csa_ctrl_pkg::amp_route_s [2:0] amp_route
);
  import csa_ctrl_pkg::*;

  // Pin synchroniser for the reference comparator
  logic [2:0] vref_sync_r, vref_sync_nxt;
  logic vref_lvl_r, vref_lvl_nxt;

  always_comb begin
    vref_sync_nxt = {vref_sync_r[1:0], vref_ok};
    vref_lvl_nxt = vref_lvl_r;
    if (vref_sync_r[2] == vref_sync_r[1]) begin
      vref_lvl_nxt = vref_sync_r[2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vref_sync_r <= 3'h0;
      vref_lvl_r <= 1'b0;
    end else begin
      vref_sync_r <= vref_sync_nxt;
      vref_lvl_r <= vref_lvl_nxt;
    end
  end

  // Registers
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [2:0] trim_bits_r, trim_bits_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0] run_req;
  logic wr_fire;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  // Handshake readies are kept as registered copies so every bus output leaves a flop
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic arready_r, arready_nxt;

  // Trim sequencer
  trim_state_e state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [2:0] trim_mask_r, trim_mask_nxt;
  logic [2:0] pend_r, pend_nxt;
  logic [1:0] gain_out_r, gain_out_nxt;
  logic lsref_r, lsref_nxt;
  logic [2:0] active_r, active_nxt;
  amp_route_s [2:0] lane_route;

  wire logic sw_if = ctrl_r[ctl_swif_bit];
  wire logic [1:0] gain_prog = ctrl_r[ctl_gain_lsb +: 2];
  wire logic runtime_trim = ctrl_r[ctl_runtrim_bit];

  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;

  always_comb begin
    wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    ctrl_nxt = ctrl_r;
    trim_bits_nxt = trim_bits_r;
    run_req = 3'h0;
    if (s_axi_awvalid && !aw_got_r) begin
      aw_got_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_r) begin
      w_got_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = resp_okay;
      unique case (aw_addr_r)
        ctrl_addr: begin
          // Variant strap bit is read-only
          ctrl_nxt[5:0] = (ctrl_r[5:0] & ~wmask[5:0]) | (w_data_r[5:0] & wmask[5:0]); // RQ16 RQ4
        end
        trim_addr: begin
          if (w_strb_r[0]) begin
            if (runtime_trim) begin
              run_req = w_data_r[2:0] & ~trim_bits_r; // RQ10
            end else if (sw_if) begin
              trim_bits_nxt = w_data_r[2:0]; // RQ3 RQ18 RQ6
            end
          end
        end
        default: bresp_nxt = resp_slverr;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    awready_nxt = !aw_got_nxt;
    wready_nxt = !w_got_nxt;
  end

  always_comb begin
    rd_val = 32'h0;
    rresp_nxt = resp_okay;
    unique case (s_axi_araddr)
      ctrl_addr: rd_val = ctrl_r;
      trim_addr: rd_val = {29'h0, trim_bits_r};
      status_addr: rd_val = {24'h0, lsref_r, gain_out_r, 1'b0, state_r == st_run,
                             active_r};
      route_addr: rd_val = {8'h0, 2'h0, lane_route[2], 2'h0, lane_route[1], 2'h0,
                            lane_route[0]};
      default: rresp_nxt = resp_slverr;
    endcase
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    if (rvalid_r) begin
      rresp_nxt = rresp_r;
      if (s_axi_rready) begin
        rvalid_nxt = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_val;
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= ctrl_reset;
      trim_bits_r <= 3'h0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= resp_okay;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      trim_bits_r <= trim_bits_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= resp_okay;
      rdata_r <= 32'h0;
      arready_r <= 1'b1;
    end else begin
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      arready_r <= arready_nxt;
    end
  end

  // Power-up trim on all lanes; run-time reruns queue so none is lost mid-trim
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    trim_mask_nxt = trim_mask_r;
    pend_nxt = pend_r | run_req;
    unique case (state_r)
      st_wait_ref: begin
        if (vref_lvl_r) begin
          state_nxt = st_trim; // RQ7
          trim_mask_nxt = 3'h7;
          cnt_nxt = 32'(trim_len - 1);
        end
      end
      st_trim: begin
        if (cnt_r == 32'h0) begin
          state_nxt = st_run; // RQ9 RQ19
          trim_mask_nxt = 3'h0;
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      st_run: begin
        if (pend_nxt != 3'h0) begin
          state_nxt = st_trim; // RQ10
          trim_mask_nxt = pend_nxt;
          pend_nxt = 3'h0;
          cnt_nxt = 32'(step_cycles - 1);
        end
      end
      default: begin
        state_nxt = st_wait_ref;
      end
    endcase
    // Gain forced for every lane while any trim runs
    gain_out_nxt = (state_nxt == st_trim) ? gain_max : gain_prog; // RQ11 RQ19
    active_nxt = trim_mask_nxt;
    // High-side reference is fixed, only the low-side choice is steered here
    lsref_nxt = ctrl_r[ctl_xdrop_bit] ? 1'b1 : ctrl_r[ctl_lsref_bit]; // RQ13 RQ17
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= st_wait_ref;
      cnt_r <= 32'h0;
      trim_mask_r <= 3'h0;
      pend_r <= 3'h0;
      gain_out_r <= 2'h0;
      lsref_r <= 1'b0;
      active_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      trim_mask_r <= trim_mask_nxt;
      pend_r <= pend_nxt;
      gain_out_r <= gain_out_nxt;
      lsref_r <= lsref_nxt;
      active_r <= active_nxt;
    end
  end

  for (genvar i = 0; i < n_amps; i++) begin : g_lane
    amp_lane u_lane (
      .aclk(aclk),
      .aresetn(aresetn),
      .man_cal(trim_bits_r[i]),
      .auto_trim(trim_mask_r[i]),
      .xdrop(ctrl_r[ctl_xdrop_bit]),
      .vref_full(ctrl_r[ctl_vref_full_bit]),
      .drive_done(gate_drive_window_done[i]),
      .ls_off_cmd(lowside_off_cmd[i]),
      .route(lane_route[i])
    );
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign amp_gain = gain_out_r;
  assign amp_trim_active = active_r;
  assign lowside_monitor_ref_neg = lsref_r;
  assign amp_route = lane_route;
endmodule

// ==== tb/csa_ctrl_checker.sv ====
// Port-level assertions for the shunt amplifier control block
module csa_ctrl_checker
  import csa_ctrl_pkg::*;
#(
  parameter int unsigned trim_len = 20
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [2:0] lowside_off_cmd,
  input wire logic [1:0] amp_gain,
  input wire logic [2:0] amp_trim_active,
  input wire logic lowside_monitor_ref_neg,
  input wire csa_ctrl_pkg::amp_route_s [2:0] amp_route
);
  timeunit 1ns;
  timeprecision 100ps;
  import csa_ctrl_pkg::*;
  logic [2:0] cs, lo, pp, ins, ov, bd;
  logic [15:0] tcnt_r, tcnt_nxt;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cs[i] = amp_route[i].cal_short;
      lo[i] = amp_route[i].load_off;
      pp[i] = amp_route[i].pos_to_phase;
      ins[i] = amp_route[i].in_short;
      ov[i] = amp_route[i].out_valid;
      bd[i] = amp_route[i].bidir;
    end
  end
  // Back-to-back queued trims would add up, so the bound holds per trim run only
  always_comb tcnt_nxt = (|amp_trim_active) ? tcnt_r + 16'h1 : 16'h0;
  always_ff @(posedge aclk) tcnt_r <= aresetn ? tcnt_nxt : 16'h0;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_gain_max;
    (|amp_trim_active) && $past(|amp_trim_active) |-> amp_gain == gain_max;
  endproperty
  a_gain_max: assert property (p_gain_max) else $error("gain not max in trim");
  property p_cal_load;
    cs == lo;
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("short and load split");
  property p_ref_neg;
    $rose(pp[0]) |-> ##[0:1] lowside_monitor_ref_neg;
  endproperty
  a_ref_neg: assert property (p_ref_neg) else $error("monitor ref not neg");
  property p_short;
    pp[0] && lowside_off_cmd[0] && $past(pp[0] && lowside_off_cmd[0]) |-> ins[0];
  endproperty
  a_short: assert property (p_short) else $error("inputs not shorted");
  property p_ov_trim;
    amp_trim_active[0] && $past(amp_trim_active[0]) |-> !ov[0];
  endproperty
  a_ov_trim: assert property (p_ov_trim) else $error("output valid in trim");
  property p_bidir;
    bd == 3'h0 || bd == 3'h7;
  endproperty
  a_bidir: assert property (p_bidir) else $error("lanes differ in ref mode");
  property p_tlen;
    tcnt_r <= trim_len;
  endproperty
  a_tlen: assert property (p_tlen) else $error("trim runs too long");
  property p_bstand;
    $fell(s_axi_bvalid) |-> $past(s_axi_bready);
  endproperty
  a_bstand: assert property (p_bstand) else $error("write response dropped");
  property p_rstand;
    $fell(s_axi_rvalid) |-> $past(s_axi_rready);
  endproperty
  a_rstand: assert property (p_rstand) else $error("read response dropped");
endmodule
bind shunt_amp_cal_mode_ctrl csa_ctrl_checker #(.trim_len(trim_len)) chk_u (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .lowside_off_cmd, .amp_gain, .amp_trim_active, .lowside_monitor_ref_neg, .amp_route);

// ==== tb/gate_side_model.sv ====
// Gate-drive side model: reference supply and low-side switching commands
module gate_side_model (
  input wire logic aclk,
  input wire logic supply_on,
  input wire logic [2:0] ls_on,
  output logic vref_ok,
  output logic [2:0] gate_drive_window_done,
  output logic [2:0] lowside_off_cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] d1 = '0, d2 = '0;
  initial vref_ok = 1'h0;
  initial gate_drive_window_done = '0;
  initial lowside_off_cmd = 3'h7;
  always @(posedge aclk) begin
    vref_ok <= supply_on;
    d1 <= ls_on;
    d2 <= d1;
    // Window elapses a few cycles after each low-side turn-on
    gate_drive_window_done <= d2 & ls_on;
    lowside_off_cmd <= ~ls_on;
  end
endmodule

// ==== tb/tb_shunt_amp_cal_mode_ctrl.sv ====
// Self-checking bench for the shunt amplifier control block
module tb_shunt_amp_cal_mode_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import csa_ctrl_pkg::*;
  localparam int unsigned tl = 20;
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, supply_on = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, rv, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [2:0] ls_on = '0, v, gate_drive_window_done, lowside_off_cmd, amp_trim_active;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, vref_ok;
  logic lowside_monitor_ref_neg;
  logic [1:0] s_axi_bresp, s_axi_rresp, amp_gain, rs;
  amp_route_s [2:0] amp_route;
  int mismatches = 0, compares = 0, c;
  // Model of the control word: each write queues what the next read must return
  int unsigned exp_q[$];
  always #12.5 aclk = ~aclk;
  shunt_amp_cal_mode_ctrl #(.trim_len(tl)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vref_ok, .gate_drive_window_done,
    .lowside_off_cmd, .amp_gain, .amp_trim_active, .lowside_monitor_ref_neg, .amp_route);
  gate_side_model gm_u (.aclk, .supply_on, .ls_on, .vref_ok, .gate_drive_window_done,
    .lowside_off_cmd);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready === 1'h1) begin
        pa = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (pw && s_axi_wready === 1'h1) begin
        pw = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    // Ready rises once both halves are taken and holds until the answer is sampled
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic trim_run(input int n, input logic [2:0] m, input logic [1:0] g);
    int k;
    k = 0;
    while (amp_trim_active === 3'h0 && k < 50) begin
      @(posedge aclk);
      k++;
    end
    chk(32'(k < 50), 32'h1);
    k = 0;
    while (amp_trim_active !== 3'h0 && k < 5000) begin
      k++;
      if (k == 3) chk(32'(amp_gain), 32'(gain_max));
      if (k == 3) chk(32'(amp_trim_active), 32'(m));
      @(posedge aclk);
    end
    if (n > 0) chk(k, n);
    @(posedge aclk);
    chk(32'(amp_gain), 32'(g));
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #250000;
    mismatches++;
    final_report;
  end
  initial begin
    void'($urandom(72));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(ctrl_addr);
    chk(rv, ctrl_reset);
    supply_on <= 1'h1;
    trim_run(tl, 3'h7, 2'h0);
    $display("test power-up trim done");
    // Calibrate with low sides off to keep switching noise out
    repeat (3) begin
      v = 3'($urandom);
      wr(trim_addr, {29'h0, v});
      rd(route_addr);
      chk(rv & 32'h303030, {10'h0, {2{v[2]}}, 6'h0, {2{v[1]}}, 6'h0, {2{v[0]}}, 4'h0});
    end
    wr(trim_addr, 32'h0);
    rd(route_addr);
    chk(rv & 32'h303030, 32'h0);
    $display("test manual calibration done");
    for (int k = 0; k < 16; k++) begin
      c = (k / 4) * 16 + (k % 4) * 2 + int'($urandom % 2);
      wr(ctrl_addr, c);
      exp_q.push_back(32'(c) | ctrl_reset);
      rd(route_addr);
      chk(rv & 32'h010101, (c % 2) ? 32'h0 : 32'h010101);
      chk(32'(amp_gain), k / 4);
      chk(32'(lowside_monitor_ref_neg), 32'((k % 4) != 0));
      rd(ctrl_addr);
      chk(rv, exp_q.pop_front());
    end
    $display("test modes done");
    wr(ctrl_addr, 32'h2);
    ls_on <= 3'h7;
    repeat (2) @(posedge aclk);
    chk(32'(amp_route[0].out_valid), 32'h0);
    // The window ends three edges after turn-on, and the lane needs one more
    repeat (2) @(posedge aclk);
    rd(route_addr);
    chk(rv & 32'h0e0e0e, 32'h0a0a0a);
    ls_on <= 3'h0;
    rd(route_addr);
    rd(route_addr);
    chk(rv & 32'h0e0e0e, 32'h0c0c0c);
    // Status: monitor reference at bit 7, run state at bit 3, gain 0, no trim
    rd(status_addr);
    chk(rv, 32'h88);
    $display("test transistor drop done");
    wr(ctrl_addr, 32'h18);
    wr(trim_addr, 32'h1);
    trim_run(0, 3'h1, 2'h1);
    $display("test run-time trim done");
    wr(8'h10, 32'h5);
    chk(32'(rs), 32'(resp_slverr));
    rd(8'h10);
    chk(32'(rs), 32'(resp_slverr));
    $display("test unmapped done");
    final_report;
  end
endmodule
